// [hdl/dpdc_pkg.sv]
// Package: shared constants and types for the power-down control block
package dpdc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int REF_CLK_HZ    = 10_000_000;
	localparam int REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
	localparam int CKELCK_NS     = 5;      // Receivers stay alive this long after CKE falls
	localparam int CKELCK_NCK    = 5;      // Same hold, in link clock cycles
	localparam int XP_NS         = 8;      // Exit latency after CKE rises
	localparam int XP_CYC        = (XP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [3:0] XP_CYC_W = 4'(XP_CYC < 1 ? 1 : XP_CYC);
	localparam logic [3:0] CKELCK_CNT_W = 4'(CKELCK_NCK);

	// ----------------------------------------------------------------
	// Power-down kinds and state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		DPDC_ACTIVE = 4'h1,
		DPDC_ENTRY  = 4'h2,
		DPDC_DOWN   = 4'h4,
		DPDC_EXIT   = 4'h8
	} dpdc_state_t;

	typedef enum logic [1:0] {
		DPDC_PD_NONE = 2'h0,
		DPDC_PD_IDLE = 2'h1,
		DPDC_PD_ACT  = 2'h2,
		DPDC_PD_SREF = 2'h3
	} dpdc_kind_t;

	// Core status bundle presented to the block
	typedef struct packed {
		logic banks_open;
		logic self_refresh;
		logic internal_busy;
		logic odt_ca_en;
		logic odt_ck_en;
		logic odt_cs_en;
		logic odt_pad_en;
		logic vddq_ok;
	} dpdc_core_t;

	// Receiver and buffer enables driven by the block
	typedef struct packed {
		logic io_buf_en;
		logic ca_rx_en;
		logic cs_rx_en;
		logic ck_rx_en;
		logic cmd_term_en;
	} dpdc_pads_t;

	// Decides whether termination survives any state
	function automatic logic dpdc_term(input dpdc_core_t c);
		return (c.odt_ca_en | c.odt_ck_en | c.odt_cs_en) & c.odt_pad_en & c.vddq_ok;
	endfunction

endpackage

// [hdl/dpdc_link_rx.sv]
// Link-clock side: CKE sampling and receiver hold after CKE falls
`timescale 1ns/10ps
module dpdc_link_rx (
	input  wire logic link_clk,
	input  wire logic srst_link,
	input  wire logic cke_pin,
	output logic      cke_link,
	output logic      rx_hold
);

	logic       cke_s1;
	logic [3:0] hold_cnt;

	// ----------------------------------------------------------------
	// CKE synchroniser and tCKELCK counter on the device clock
	// ----------------------------------------------------------------
	// The clock may stop after the hold; rx_hold then just stays low
	always_ff @(posedge link_clk) begin
		if (srst_link) begin
			cke_s1   <= 1'b0;
			cke_link <= 1'b0;
			hold_cnt <= 4'h0;
			rx_hold  <= 1'b0;
		end else begin
			cke_s1   <= cke_pin;
			cke_link <= cke_s1;
			if (cke_link) begin
				hold_cnt <= dpdc_pkg::CKELCK_CNT_W;
				rx_hold  <= 1'b1;
			end else if (hold_cnt != 4'h0) begin
				hold_cnt <= hold_cnt - 4'h1;
			end else begin
				rx_hold  <= 1'b0;
			end
		end
	end

endmodule

// [hdl/dpdc_top.sv]
// Top: power-down entry, exit and receiver control of the DRAM die
`timescale 1ns/10ps
// Behaviour
// - CKE low enters power-down with no command needed.
// - Activate, precharge or refresh finish inside; low power only after.
// - Entry disables input and output buffers except CKE and reset.
// - After tCKELCK expires all receivers except CKE and reset go off.
// - No refresh in power-down except self-refresh power-down.
// - CKE high exits power-down; host holds it high tCKE min.
// - Idle power-down with all banks idle, active if a row open.
// - Self-refresh power-down keeps refreshing as in self refresh.
// - Enabled command-bus termination persists in all states with VDDQ valid.
module dpdc_top (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              clk_en,
	input  wire logic              link_clk,
	input  wire logic              srst_link,
	input  wire logic              cke_pin,
	input  wire dpdc_pkg::dpdc_core_t core_in,
	output dpdc_pkg::dpdc_pads_t   pads,
	output logic                   pd_active,
	output logic                   pd_low_power,
	output dpdc_pkg::dpdc_kind_t   pd_kind,
	output logic                   refresh_allow,
	output logic                   cmd_ready,
	output logic                   state_hold
);

	logic                  rx_hold;
	logic                  cke_r1;
	logic                  cke_r2;
	logic                  hold_r1;
	logic                  hold_r2;
	dpdc_pkg::dpdc_core_t  core_r;
	dpdc_pkg::dpdc_state_t state;
	dpdc_pkg::dpdc_state_t next_state;
	logic [3:0]            xp_cnt;
	logic [3:0]            next_xp_cnt;

	// ----------------------------------------------------------------
	// Link-facing sampler, on the device clock
	// ----------------------------------------------------------------
	dpdc_link_rx u_link (
		.link_clk  (link_clk),
		.srst_link (srst_link),
		.cke_pin   (cke_pin),
		.cke_link  (),
		.rx_hold   (rx_hold)
	);

	// ----------------------------------------------------------------
	// Crossing into ref_clk: two flops for each level
	// ----------------------------------------------------------------
	// Raw CKE is used, not cke_link, so entry works with the clock stopped
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cke_r1  <= 1'b1;
			cke_r2  <= 1'b1;
			hold_r1 <= 1'b0;
			hold_r2 <= 1'b0;
			core_r  <= '0;
		end else if (clk_en) begin
			cke_r1  <= cke_pin;
			cke_r2  <= cke_r1;
			hold_r1 <= rx_hold;
			hold_r2 <= hold_r1;
			core_r  <= core_in;       // Same-domain status, registered once
		end
	end

	// ----------------------------------------------------------------
	// Power-down sequencing decode
	// ----------------------------------------------------------------
	wire cke_low   = ~cke_r2;
	wire term_keep = dpdc_pkg::dpdc_term(core_r);
	wire busy_done = ~core_r.internal_busy;
	wire xp_done   = (xp_cnt == 4'h0);
	wire [1:0] kind_sel = core_r.self_refresh ? dpdc_pkg::DPDC_PD_SREF :
		(core_r.banks_open ? dpdc_pkg::DPDC_PD_ACT : dpdc_pkg::DPDC_PD_IDLE);

	// Next state: entry needs only CKE, exit likewise
	always_comb begin
		next_state  = state;
		next_xp_cnt = xp_cnt;
		case (state)
			dpdc_pkg::DPDC_ACTIVE: begin
				if (cke_low) begin
					next_state = dpdc_pkg::DPDC_ENTRY;
				end
			end
			dpdc_pkg::DPDC_ENTRY: begin
				if (!cke_low) begin
					next_state  = dpdc_pkg::DPDC_EXIT;
					next_xp_cnt = dpdc_pkg::XP_CYC_W;
				end else if (busy_done) begin
					next_state = dpdc_pkg::DPDC_DOWN;
				end
			end
			dpdc_pkg::DPDC_DOWN: begin
				if (!cke_low) begin
					next_state  = dpdc_pkg::DPDC_EXIT;
					next_xp_cnt = dpdc_pkg::XP_CYC_W;
				end
			end
			dpdc_pkg::DPDC_EXIT: begin
				if (cke_low) begin
					next_state = dpdc_pkg::DPDC_ENTRY;
				end else if (xp_done) begin
					next_state = dpdc_pkg::DPDC_ACTIVE;
				end else begin
					next_xp_cnt = xp_cnt - 4'h1;
				end
			end
			default: begin
				next_state  = dpdc_pkg::DPDC_ACTIVE;
				next_xp_cnt = 4'h0;
			end
		endcase
	end

	wire in_pd     = (state == dpdc_pkg::DPDC_ENTRY) | (state == dpdc_pkg::DPDC_DOWN);
	wire rx_keep   = ~in_pd | hold_r2;
	wire next_low  = (next_state == dpdc_pkg::DPDC_DOWN);

	// ----------------------------------------------------------------
	// State and registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= dpdc_pkg::DPDC_ACTIVE;
			xp_cnt <= 4'h0;
		end else if (clk_en) begin
			state  <= next_state;
			xp_cnt <= next_xp_cnt;
		end
	end

	// Pad enables; termination ignores power state on purpose
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pads          <= '0;
			pd_active     <= 1'b0;
			pd_low_power  <= 1'b0;
			pd_kind       <= dpdc_pkg::DPDC_PD_NONE;
			refresh_allow <= 1'b1;
			cmd_ready     <= 1'b0;
			state_hold    <= 1'b0;
		end else if (clk_en) begin
			pads.io_buf_en   <= ~in_pd;
			pads.ca_rx_en    <= rx_keep;
			pads.cs_rx_en    <= rx_keep;
			pads.ck_rx_en    <= rx_keep;
			pads.cmd_term_en <= term_keep;
			pd_active        <= in_pd;
			pd_low_power     <= next_low;
			if (state == dpdc_pkg::DPDC_ACTIVE && cke_low) begin
				pd_kind <= dpdc_pkg::dpdc_kind_t'(kind_sel);
			end else if (state == dpdc_pkg::DPDC_ACTIVE) begin
				pd_kind <= dpdc_pkg::DPDC_PD_NONE;
			end
			// Outside self refresh the array must not refresh while down
			refresh_allow <= ~in_pd | core_r.self_refresh;
			cmd_ready     <= (state == dpdc_pkg::DPDC_ACTIVE) & ~cke_low;
			// Freezes mode registers and row state in the core
			state_hold    <= in_pd | (state == dpdc_pkg::DPDC_EXIT);
		end
	end

endmodule

// [dv/dpdc_host_model.sv]
// Host model: drives CKE and the device clock around power-down
`timescale 1ns/10ps
module dpdc_host_model (
	input  wire logic ref_clk,
	input  wire logic sleep_req,
	output logic      cke_pin,
	output logic      link_clk
);
	logic run = 1'b1;
	initial cke_pin = 1'b1;
	initial link_clk = 1'b0;
	// Clock stands still at low while stopped in power-down
	always #40 link_clk = run & ~link_clk;
	// One power-down period per request, clock kept past the receiver hold
	always begin
		wait (sleep_req);
		// Stands in for the last command's delay to CKE low: no burst, mode
		// register access, training or oscillator run is left open here
		repeat (6) @(negedge ref_clk);
		@(negedge ref_clk) cke_pin = 1'b0;
		repeat (10) @(posedge link_clk);
		run = 1'b0;
		wait (!sleep_req);
		run = 1'b1;
		repeat (4) @(posedge link_clk);
		@(negedge ref_clk) cke_pin = 1'b1;
		repeat (40) @(negedge ref_clk);
	end
endmodule

// [dv/dpdc_monitor.sv]
// Checker: port timing of power-down entry, exit and receivers
`timescale 1ns/10ps
module dpdc_monitor (
	input wire logic                 ref_clk,
	input wire logic                 srst,
	input wire logic                 cke_pin,
	input wire dpdc_pkg::dpdc_core_t core_in,
	input wire dpdc_pkg::dpdc_pads_t pads,
	input wire logic                 pd_active,
	input wire logic                 pd_low_power,
	input wire dpdc_pkg::dpdc_kind_t pd_kind,
	input wire logic                 refresh_allow,
	input wire logic                 cmd_ready
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// Termination asked for by the core, power state plays no part
	wire term = (core_in.odt_ca_en | core_in.odt_ck_en | core_in.odt_cs_en)
		& core_in.odt_pad_en & core_in.vddq_ok;
	sequence s_down;
		!cke_pin [*8];
	endsequence
	sequence s_wake;
		!cmd_ready [*5] ##[0:4] cmd_ready;
	endsequence
	AST_ENTRY: assert property ($fell(cke_pin) ##1 !cke_pin [*5] |-> ##[0:1] pd_active)
		else $error("no entry");
	AST_BUF: assert property (pd_active |-> !pads.io_buf_en)
		else $error("buffers on");
	AST_RXHOLD: assert property ($fell(cke_pin) |-> pads.ca_rx_en [*4])
		else $error("rx off early");
	AST_RXOFF: assert property (s_down |-> ##[0:8]
		!(pads.ca_rx_en | pads.cs_rx_en | pads.ck_rx_en))
		else $error("rx still on");
	// Status is registered once inside, then the pad flop: two cycles of latency
	AST_TERM: assert property (!$past(srst) && !$past(srst, 2) |->
		pads.cmd_term_en == $past(term, 2))
		else $error("term wrong");
	AST_NOREF: assert property (pd_active && $past(pd_active, 2)
		&& pd_kind != dpdc_pkg::DPDC_PD_SREF |-> !refresh_allow)
		else $error("refresh in pd");
	AST_SREF: assert property (pd_active && pd_kind == dpdc_pkg::DPDC_PD_SREF
		|-> refresh_allow)
		else $error("sref stopped");
	AST_KIND: assert property ($rose(pd_active) && !core_in.self_refresh
		|-> pd_kind == (core_in.banks_open ? dpdc_pkg::DPDC_PD_ACT : dpdc_pkg::DPDC_PD_IDLE))
		else $error("kind wrong");
	AST_LOWPWR: assert property (core_in.internal_busy && $past(core_in.internal_busy)
		|-> !pd_low_power)
		else $error("low power early");
	AST_EXIT: assert property ($rose(cke_pin) && pd_active |-> s_wake)
		else $error("exit timing");
endmodule
bind dpdc_top dpdc_monitor mon_u (.ref_clk, .srst, .cke_pin, .core_in, .pads, .pd_active,
	.pd_low_power, .pd_kind, .refresh_allow, .cmd_ready);

// [dv/tb.sv]
// Testbench: power-down entry, exit and its variants at the ports
`timescale 1ns/10ps
module tb;
	logic ref_clk = 1'b0, srst = 1'b1, srst_link = 1'b1, sleep_req = 1'b0;
	logic cke_pin, link_clk, pd_active, pd_low_power, refresh_allow, cmd_ready, state_hold;
	dpdc_pkg::dpdc_core_t core_in = '0;
	dpdc_pkg::dpdc_pads_t pads;
	dpdc_pkg::dpdc_kind_t pd_kind;
	int err_total = 0, n_compared = 0;
	// Core clock
	always #50 ref_clk = ~ref_clk;
	dpdc_host_model host_u (.ref_clk, .sleep_req, .cke_pin, .link_clk);
	dpdc_top dut_u (.ref_clk, .srst, .clk_en(1'b1), .link_clk, .srst_link, .cke_pin,
		.core_in, .pads, .pd_active, .pd_low_power, .pd_kind, .refresh_allow,
		.cmd_ready, .state_hold);
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		n_compared++;
		if (got !== want) begin
			err_total++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	task automatic stop_test;
		$display("compared=%0d errors=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Sleep with a given core status, check the down state, release busy, wake
	task automatic pd_cycle(input dpdc_pkg::dpdc_core_t c, input dpdc_pkg::dpdc_kind_t k);
		@(negedge ref_clk) core_in = c;
		sleep_req = 1'b1;
		// The host still holds CKE high from the last wake; count from the fall
		wait (!cke_pin);
		repeat (20) @(negedge ref_clk);
		chk({pd_active, pads.io_buf_en, state_hold}, 8'h05);
		chk({pads.ca_rx_en, pads.cs_rx_en, pads.ck_rx_en}, 8'h00);
		chk(pd_kind, k);
		chk(refresh_allow, k == dpdc_pkg::DPDC_PD_SREF);
		chk(pd_low_power, !c.internal_busy);
		chk(pads.cmd_term_en, (c.odt_ca_en | c.odt_ck_en | c.odt_cs_en)
			& c.odt_pad_en & c.vddq_ok);
		core_in.internal_busy = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(pd_low_power, 1'b1);
		sleep_req = 1'b0;
		wait (cke_pin);
		repeat (8) @(negedge ref_clk);
		chk({cmd_ready, pd_active, state_hold}, 8'h04);
		$display("pd test done kind=%0d", k);
	endtask
	// Main sequence: reset values, then idle, active, self-refresh variants
	initial begin
		repeat (6) @(negedge ref_clk);
		chk({pads, pd_active, refresh_allow}, 8'h01);
		chk({pd_low_power, pd_kind, cmd_ready, state_hold}, 8'h00);
		srst = 1'b0;
		// Released off the link clock's rising edge to avoid a race there
		@(negedge link_clk) srst_link = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(cmd_ready, 1'b1);
		$display("reset test done");
		pd_cycle(dpdc_pkg::dpdc_core_t'(8'h13), dpdc_pkg::DPDC_PD_IDLE);
		pd_cycle(dpdc_pkg::dpdc_core_t'(8'hA9), dpdc_pkg::DPDC_PD_ACT);
		pd_cycle(dpdc_pkg::dpdc_core_t'(8'h67), dpdc_pkg::DPDC_PD_SREF);
		pd_cycle(dpdc_pkg::dpdc_core_t'(8'h32), dpdc_pkg::DPDC_PD_IDLE);
		stop_test();
	end
	// Watchdog: the four cycles need about 280 clocks, allow far more
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule
